// file: rtl/lsn_ctrl_end.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Radio controller unit end of the start-up negotiation
// Function
// - Control words match advertised protocol version.
// - Rate switch gaps stay below 0.1 s.
// - Hyperframe sync within 0.2 s when clean.
// - Evaluate received words every 0.1 s.
// - Supervision timer runs from start until link.
// - Listed transitions start or clear supervision.
// - Expiry re-enters synchronisation state.
// - Expiry period is an implementation setting.
// - Standby neither transmits nor receives.
// - Controller starts at highest rate both ways.
// - Controller steps rate each dwell, wrapping.
// - Controller advertises highest version and rates.
// - Equipment steps receive rate each longer dwell.
// - Equipment transmits only after sync, same rate.
// - Equipment advertises rule or highest values.
// - Controller picks highest version entering setup.
// - Controller reselects version not above received.
// - Setup done when received equals transmitted version.
// - Equipment reselects version not above received.
// - Control bits not acted on in setup.
// - Version mismatch returns to protocol setup.
module lsn_ctrl_end #(
  parameter int DWELL_CYC = lsn_pkg::CTRL_DWELL_CYC, // Rate dwell
  parameter int EVAL_CYC = lsn_pkg::EVAL_CYC, // Evaluation period
  parameter int SUP_CYC = lsn_pkg::SUP_CYC, // Supervision expiry
  parameter int LINK_HALF = lsn_pkg::LINK_HALF_CYC // Link clock half period
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  lsn_link_if.ctrl_end link,
  input wire logic start_in,
  input wire logic [lsn_pkg::NRATE-1:0] rate_mask_in,
  input wire logic [lsn_pkg::NVER-1:0] ver_mask_in,
  input wire logic [lsn_pkg::CMR_W-1:0] hdlc_top_in,
  input wire logic [lsn_pkg::CMR_W-1:0] eth_top_in,
  input wire logic hfn_sync_in,
  input wire logic cm_link_up_in,
  output logic [lsn_pkg::RATE_W-1:0] line_rate_out,
  output logic rx_enable_out,
  output logic tx_enable_out,
  output logic [lsn_pkg::VER_W-1:0] ver_out,
  output logic ver_agreed_out,
  output logic l1_ctrl_usable_out,
  output logic sup_expired_out
);
  import lsn_pkg::*;
  // ==========================================================
  // Declarations
  localparam int SYN_W = 1 + VER_W; // Peer tx on and version
  logic [SYN_W-1:0] syn1_reg, syn2_reg; // Two stage synchroniser
  logic [SYN_W-1:0] syn3_reg; // Previous sample for stability
  lsn_state_type state_reg, state_next;
  logic [RATE_W-1:0] rate_reg, rate_next; // Shared tx and rx rate
  logic [VER_W-1:0] ver_reg, ver_next; // Advertised version
  logic [CNT_W-1:0] dwell_reg, dwell_next;
  logic [CNT_W-1:0] eval_reg, eval_next;
  logic [CNT_W-1:0] sup_reg, sup_next;
  logic sup_run_reg, sup_run_next;
  logic exp_reg, exp_next; // Expiry pulse
  logic [CNT_W-1:0] div_reg, div_next; // Link clock divider
  logic lclk_reg, lclk_next; // Link clock level
  logic dl_on_reg, dl_on_next; // Downlink words, change at clock fall
  logic [RATE_W-1:0] dl_rate_reg, dl_rate_next;
  logic [VER_W-1:0] dl_ver_reg, dl_ver_next;
  logic rx_valid; // Peer on and word stable for two samples
  logic [VER_W-1:0] rx_ver; // Received version
  logic eval_tick; // Evaluation instant
  logic [VER_W-1:0] pick; // Reselection result
  // ==========================================================
  // Synchroniser for uplink pins
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      syn1_reg <= '0;
      syn2_reg <= '0;
      syn3_reg <= '0;
    end else begin
      syn1_reg <= {link.ul_tx_on, link.ul_ver};
      syn2_reg <= syn1_reg;
      syn3_reg <= syn2_reg;
    end
  end
  assign rx_valid = syn2_reg[VER_W] && (syn2_reg == syn3_reg);
  assign rx_ver = syn2_reg[VER_W-1:0];
  assign eval_tick = (eval_reg == CNT_W'(EVAL_CYC - 1));
  assign pick = lsn_pick(rx_ver, ver_mask_in);
  // ==========================================================
  // Next state of the start-up logic
  always_comb begin
    state_next = state_reg;
    rate_next = rate_reg;
    ver_next = ver_reg;
    dwell_next = dwell_reg;
    eval_next = eval_tick ? '0 : eval_reg + 1'b1;
    sup_next = sup_reg;
    sup_run_next = sup_run_reg;
    exp_next = 1'b0;
    // Supervision timer counts while armed
    if (sup_run_reg) begin
      sup_next = sup_reg + 1'b1;
    end
    // Management link up stops supervision
    if (cm_link_up_in) begin
      sup_run_next = 1'b0;
    end
    unique case (state_reg)
      ST_STANDBY: begin
        // Link idle until configured
        if (start_in) begin
          state_next = ST_SYNC;
          rate_next = lsn_top(rate_mask_in);
          ver_next = lsn_top(ver_mask_in);
          dwell_next = '0;
          sup_next = '0;
          sup_run_next = 1'b1;
        end
      end
      ST_SYNC: begin
        ver_next = lsn_top(ver_mask_in);
        if (hfn_sync_in) begin
          state_next = ST_PROTO; // Sync indication acted on at once
          ver_next = lsn_top(ver_mask_in);
        end else if (dwell_reg == CNT_W'(DWELL_CYC - 1)) begin
          // Tx and rx step together, same value
          rate_next = lsn_step(rate_reg, rate_mask_in); // One-cycle retune, short gap
          dwell_next = '0;
        end else begin
          dwell_next = dwell_reg + 1'b1;
        end
      end
      ST_PROTO: begin
        // Control bits are not acted on here
        if (!hfn_sync_in) begin
          state_next = ST_SYNC;
          rate_next = lsn_top(rate_mask_in);
          dwell_next = '0;
        end else if (eval_tick && rx_valid) begin
          if (rx_ver == ver_reg) begin
            state_next = ST_AGREED;
          end else begin
            ver_next = pick;
            if (pick == rx_ver) begin
              state_next = ST_AGREED;
            end
          end
        end
      end
      ST_AGREED: begin
        if (!hfn_sync_in) begin
          state_next = ST_SYNC;
          rate_next = lsn_top(rate_mask_in);
          dwell_next = '0;
        end else if (eval_tick && rx_valid && rx_ver != ver_reg) begin
          state_next = ST_PROTO;
        end
      end
    endcase
    // Expiry restarts synchronisation at the top rate
    if (sup_run_reg && sup_reg == CNT_W'(SUP_CYC - 1)) begin
      state_next = ST_SYNC;
      rate_next = lsn_top(rate_mask_in);
      ver_next = lsn_top(ver_mask_in);
      dwell_next = '0;
      sup_next = '0;
      exp_next = 1'b1;
    end
  end
  // ==========================================================
  // Next state of the link clock and downlink words
  always_comb begin
    div_next = div_reg + 1'b1;
    lclk_next = lclk_reg;
    dl_on_next = dl_on_reg;
    dl_rate_next = dl_rate_reg;
    dl_ver_next = dl_ver_reg;
    if (div_reg == CNT_W'(LINK_HALF - 1)) begin
      div_next = '0;
      lclk_next = !lclk_reg;
      // Words change only as the clock falls, so the far end samples them settled
      if (lclk_reg) begin
        dl_on_next = (state_reg != ST_STANDBY);
        dl_rate_next = rate_reg;
        dl_ver_next = ver_reg;
      end
    end
  end
  // ==========================================================
  // State registers
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_reg <= ST_STANDBY;
      rate_reg <= '0;
      ver_reg <= '0;
      dwell_reg <= '0;
      eval_reg <= '0;
      sup_reg <= '0;
      sup_run_reg <= 1'b0;
      exp_reg <= 1'b0;
      div_reg <= '0;
      lclk_reg <= 1'b0;
      dl_on_reg <= 1'b0;
      dl_rate_reg <= '0;
      dl_ver_reg <= '0;
    end else begin
      state_reg <= state_next;
      rate_reg <= rate_next;
      ver_reg <= ver_next;
      dwell_reg <= dwell_next;
      eval_reg <= eval_next;
      sup_reg <= sup_next;
      sup_run_reg <= sup_run_next;
      exp_reg <= exp_next;
      div_reg <= div_next;
      lclk_reg <= lclk_next;
      dl_on_reg <= dl_on_next;
      dl_rate_reg <= dl_rate_next;
      dl_ver_reg <= dl_ver_next;
    end
  end
  // ==========================================================
  // Outputs
  assign link.link_clk = lclk_reg;
  assign link.dl_tx_on = dl_on_reg;
  assign link.dl_rate = dl_rate_reg;
  assign link.dl_ver = dl_ver_reg;
  assign link.dl_hdlc_rate = hdlc_top_in;
  assign link.dl_eth_rate = eth_top_in;
  assign line_rate_out = rate_reg; // Retunes the serialiser
  assign rx_enable_out = (state_reg != ST_STANDBY);
  assign tx_enable_out = (state_reg != ST_STANDBY);
  assign ver_out = ver_reg; // Framer fills words to match
  assign ver_agreed_out = (state_reg == ST_AGREED);
  assign l1_ctrl_usable_out = (state_reg == ST_AGREED);
  assign sup_expired_out = exp_reg;
endmodule
`default_nettype wire

// file: rtl/lsn_equip_end.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Radio equipment unit end of the start-up negotiation
module lsn_equip_end #(
  parameter int DWELL_CYC = lsn_pkg::EQ_DWELL_CYC, // Receive rate dwell
  parameter int EVAL_CYC = lsn_pkg::EVAL_CYC, // Evaluation period
  parameter int SUP_CYC = lsn_pkg::SUP_CYC // Supervision expiry
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  lsn_link_if.equip_end link,
  input wire logic start_in,
  input wire logic [lsn_pkg::NRATE-1:0] rate_mask_in,
  input wire logic [lsn_pkg::NVER-1:0] ver_mask_in,
  input wire logic [lsn_pkg::CMR_W-1:0] hdlc_top_in,
  input wire logic [lsn_pkg::CMR_W-1:0] eth_top_in,
  input wire logic hfn_sync_in,
  input wire logic cm_link_up_in,
  output logic [lsn_pkg::RATE_W-1:0] line_rate_out,
  output logic rx_enable_out,
  output logic tx_enable_out,
  output logic [lsn_pkg::VER_W-1:0] ver_out,
  output logic ver_agreed_out,
  output logic l1_ctrl_usable_out,
  output logic sup_expired_out
);
  import lsn_pkg::*;
  // ==========================================================
  // Declarations
  localparam int SYN_W = 2 + VER_W; // Link clock, tx on, version
  logic [SYN_W-1:0] syn1_reg, syn2_reg; // Two stage synchroniser
  logic clk_d_reg; // Delayed link clock for edge find
  logic [VER_W-1:0] rx_ver_reg, rx_ver_next; // Captured peer version
  logic rx_on_reg, rx_on_next; // Captured peer transmitter state
  lsn_state_type state_reg, state_next;
  logic [RATE_W-1:0] rate_reg, rate_next; // Shared rx and tx rate
  logic [VER_W-1:0] ver_reg, ver_next; // Advertised version
  logic tx_reg, tx_next; // Transmitter on
  logic [CNT_W-1:0] dwell_reg, dwell_next;
  logic [CNT_W-1:0] eval_reg, eval_next;
  logic [CNT_W-1:0] sup_reg, sup_next;
  logic sup_run_reg, sup_run_next;
  logic exp_reg, exp_next; // Expiry pulse
  logic link_rise; // Sampled link clock rising edge
  logic eval_tick; // Evaluation instant
  // ==========================================================
  // Synchroniser for pins driven from the other end
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      syn1_reg <= '0;
      syn2_reg <= '0;
      clk_d_reg <= 1'b0;
    end else begin
      syn1_reg <= {link.link_clk, link.dl_tx_on, link.dl_ver};
      syn2_reg <= syn1_reg;
      clk_d_reg <= syn2_reg[SYN_W-1];
    end
  end
  assign link_rise = syn2_reg[SYN_W-1] && !clk_d_reg;
  assign eval_tick = (eval_reg == CNT_W'(EVAL_CYC - 1));
  // ==========================================================
  // Next state of the start-up logic
  always_comb begin
    rx_ver_next = rx_ver_reg;
    rx_on_next = rx_on_reg;
    state_next = state_reg;
    rate_next = rate_reg;
    ver_next = ver_reg;
    tx_next = tx_reg;
    dwell_next = dwell_reg;
    eval_next = eval_tick ? '0 : eval_reg + 1'b1;
    sup_next = sup_reg;
    sup_run_next = sup_run_reg;
    exp_next = 1'b0;
    // Capture downlink words on link clock rise
    if (link_rise) begin
      rx_ver_next = syn2_reg[VER_W-1:0];
      rx_on_next = syn2_reg[VER_W];
    end
    // Supervision timer
    if (sup_run_reg) begin
      sup_next = sup_reg + 1'b1;
    end
    if (cm_link_up_in) begin
      sup_run_next = 1'b0;
    end
    unique case (state_reg)
      ST_STANDBY: begin
        tx_next = 1'b0;
        if (start_in) begin
          state_next = ST_SYNC;
          rate_next = lsn_top(rate_mask_in);
          ver_next = lsn_top(ver_mask_in);
          dwell_next = '0;
          sup_next = '0;
          sup_run_next = 1'b1;
        end
      end
      ST_SYNC: begin
        tx_next = 1'b0;
        if (hfn_sync_in) begin
          tx_next = 1'b1;
          state_next = ST_PROTO;
        end else if (dwell_reg == CNT_W'(DWELL_CYC - 1)) begin
          rate_next = lsn_step(rate_reg, rate_mask_in);
          dwell_next = '0;
        end else begin
          dwell_next = dwell_reg + 1'b1;
        end
      end
      ST_PROTO: begin
        // Control bits are not acted on here
        if (!hfn_sync_in) begin
          state_next = ST_SYNC;
          dwell_next = '0;
        end else if (eval_tick && rx_on_reg) begin
          if (rx_ver_reg == ver_reg) begin
            state_next = ST_AGREED;
          end else begin
            ver_next = lsn_pick(rx_ver_reg, ver_mask_in);
            if (lsn_pick(rx_ver_reg, ver_mask_in) == rx_ver_reg) begin
              state_next = ST_AGREED;
            end
          end
        end
      end
      ST_AGREED: begin
        if (!hfn_sync_in) begin
          state_next = ST_SYNC;
          dwell_next = '0;
        end else if (eval_tick && rx_on_reg && rx_ver_reg != ver_reg) begin
          state_next = ST_PROTO;
        end
      end
    endcase
    // Expiry restarts synchronisation
    if (sup_run_reg && sup_reg == CNT_W'(SUP_CYC - 1)) begin
      state_next = ST_SYNC;
      rate_next = lsn_top(rate_mask_in);
      tx_next = 1'b0;
      dwell_next = '0;
      sup_next = '0;
      exp_next = 1'b1;
    end
  end
  // ==========================================================
  // State registers
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rx_ver_reg <= '0;
      rx_on_reg <= 1'b0;
      state_reg <= ST_STANDBY;
      rate_reg <= '0;
      ver_reg <= '0;
      tx_reg <= 1'b0;
      dwell_reg <= '0;
      eval_reg <= '0;
      sup_reg <= '0;
      sup_run_reg <= 1'b0;
      exp_reg <= 1'b0;
    end else begin
      rx_ver_reg <= rx_ver_next;
      rx_on_reg <= rx_on_next;
      state_reg <= state_next;
      rate_reg <= rate_next;
      ver_reg <= ver_next;
      tx_reg <= tx_next;
      dwell_reg <= dwell_next;
      eval_reg <= eval_next;
      sup_reg <= sup_next;
      sup_run_reg <= sup_run_next;
      exp_reg <= exp_next;
    end
  end
  // ==========================================================
  // Outputs
  assign link.ul_tx_on = tx_reg;
  assign link.ul_rate = rate_reg; // Transmit at the received rate
  assign link.ul_ver = ver_reg;
  assign link.ul_hdlc_rate = hdlc_top_in;
  assign link.ul_eth_rate = eth_top_in;
  assign line_rate_out = rate_reg;
  assign rx_enable_out = (state_reg != ST_STANDBY);
  assign tx_enable_out = tx_reg;
  assign ver_out = ver_reg; // Framer fills words to match
  assign ver_agreed_out = (state_reg == ST_AGREED);
  assign l1_ctrl_usable_out = (state_reg == ST_AGREED);
  assign sup_expired_out = exp_reg;
endmodule
`default_nettype wire

// file: rtl/lsn_link_if.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Link between the controller end and the equipment end
interface lsn_link_if;
  import lsn_pkg::*;
  logic link_clk; // Link clock made by the controller
  logic dl_tx_on; // Controller transmitter active
  logic [RATE_W-1:0] dl_rate; // Downlink line rate
  logic [VER_W-1:0] dl_ver; // Downlink protocol version word
  logic [CMR_W-1:0] dl_hdlc_rate; // Downlink slow management rate word
  logic [CMR_W-1:0] dl_eth_rate; // Downlink fast management rate word
  logic ul_tx_on; // Equipment transmitter active
  logic [RATE_W-1:0] ul_rate; // Uplink line rate
  logic [VER_W-1:0] ul_ver; // Uplink protocol version word
  logic [CMR_W-1:0] ul_hdlc_rate; // Uplink slow management rate word
  logic [CMR_W-1:0] ul_eth_rate; // Uplink fast management rate word
  // Controller side
  modport ctrl_end (
    output link_clk, dl_tx_on, dl_rate, dl_ver, dl_hdlc_rate, dl_eth_rate,
    input ul_tx_on, ul_rate, ul_ver, ul_hdlc_rate, ul_eth_rate
  );
  // Equipment side
  modport equip_end (
    input link_clk, dl_tx_on, dl_rate, dl_ver, dl_hdlc_rate, dl_eth_rate,
    output ul_tx_on, ul_rate, ul_ver, ul_hdlc_rate, ul_eth_rate
  );
endinterface
`default_nettype wire

// file: rtl/lsn_pkg.sv
// ==========================================================
// Shared constants and helpers for the start-up negotiation
package lsn_pkg;
  // ==========================================================
  // Field widths
  localparam int RATE_W = 3; // Line rate index, 7 is fastest
  localparam int NRATE = 8; // Entries in a line rate mask
  localparam int VER_W = 3; // Protocol version word
  localparam int NVER = 8; // Entries in a version mask
  localparam int CMR_W = 8; // Management rate word
  // ==========================================================
  // Timing, times in milliseconds
  localparam int CLK_KHZ = 50000; // 50 MHz system clock
  localparam int CTRL_DWELL_MS = 1000; // Controller dwell, centre of 0.9 to 1.1 s
  localparam int EQ_DWELL_MS = 4000; // Equipment dwell, centre of 3.9 to 4.1 s
  localparam int EVAL_MS = 100; // Longest gap between evaluations
  localparam int SUP_MS = 10000; // Supervision expiry, per implementation
  localparam int CTRL_DWELL_CYC = CTRL_DWELL_MS * CLK_KHZ;
  localparam int EQ_DWELL_CYC = EQ_DWELL_MS * CLK_KHZ;
  localparam int EVAL_CYC = EVAL_MS * CLK_KHZ;
  localparam int SUP_CYC = SUP_MS * CLK_KHZ;
  localparam int LINK_HALF_CYC = 4; // Half period of the link clock
  localparam int CNT_W = 32; // Timer counter width
  // ==========================================================
  // Start-up states
  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_SYNC,
    ST_PROTO,
    ST_AGREED
  } lsn_state_type;
  // ==========================================================
  // Highest set entry of a mask, zero when empty
  function automatic logic [RATE_W-1:0] lsn_top(input logic [NRATE-1:0] mask);
    logic [RATE_W-1:0] r;
    r = '0;
    for (int i = 0; i < NRATE; i++) begin
      if (mask[i]) begin
        r = RATE_W'(i);
      end
    end
    return r;
  endfunction
  // Next lower available entry, wrapping to the highest
  function automatic logic [RATE_W-1:0] lsn_step(input logic [RATE_W-1:0] cur,
                                                 input logic [NRATE-1:0] mask);
    logic [RATE_W-1:0] r;
    logic [RATE_W-1:0] idx;
    logic found;
    r = cur;
    found = 1'b0;
    for (int k = 1; k < NRATE; k++) begin
      idx = RATE_W'(cur - RATE_W'(k));
      if (!found && mask[idx]) begin
        r = idx;
        found = 1'b1;
      end
    end
    return r;
  endfunction
  // Highest available version not above the received one, else lowest
  function automatic logic [VER_W-1:0] lsn_pick(input logic [VER_W-1:0] rx,
                                                input logic [NVER-1:0] mask);
    logic [VER_W-1:0] r;
    logic found;
    r = '0;
    found = 1'b0;
    for (int i = 0; i < NVER; i++) begin
      if (mask[i] && (VER_W'(i) <= rx)) begin
        r = VER_W'(i);
        found = 1'b1;
      end
    end
    if (!found) begin
      for (int i = NVER - 1; i >= 0; i--) begin
        if (mask[i]) begin
          r = VER_W'(i);
        end
      end
    end
    return r;
  endfunction
endpackage

// file: verif/link_startup_negotiation_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Both ends joined across the link
module link_startup_negotiation_tb;
  import lsn_pkg::*;
  localparam int DW_C = 200; // Controller dwell
  localparam int DW_E = 800; // Equipment dwell
  typedef struct {
    logic [7:0] vc;
    logic [7:0] ve;
    logic [2:0] v;
  } lsn_row_type;
  // Version masks, then the version both settle on
  lsn_row_type rows [3] = '{'{8'h0f, 8'h0f, 3'h3}, '{8'h0f, 8'h06, 3'h2},
                            '{8'h0a, 8'h06, 3'h1}};
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic start = 1'b0;
  logic cm_up = 1'b0;
  logic hfn_c = 1'b0;
  logic hfn_e = 1'b0;
  logic [7:0] rmask = 8'h0a; // Rates 3 and 1
  logic [7:0] cmr = 8'h5a; // Management rate words
  logic [7:0] vm_c = 8'h0f;
  logic [7:0] vm_e = 8'h0f;
  logic [2:0] rate_c, rate_e, ver_c, ver_e;
  logic rx_c, rx_e, tx_c, tx_e, agr_c, agr_e, use_c, sup_c, use_e, sup_e;
  int bad_count = 0;
  int cmp_count = 0;
  int n;
  int hits;
  lsn_link_if lsn_link_if_i ();
  lsn_ctrl_end #(.DWELL_CYC(DW_C), .EVAL_CYC(20), .SUP_CYC(5000), .LINK_HALF(4)) lsn_ctrl_end_i (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .link(lsn_link_if_i), .start_in(start),
    .rate_mask_in(rmask), .ver_mask_in(vm_c), .hdlc_top_in(cmr), .eth_top_in(cmr),
    .hfn_sync_in(hfn_c), .cm_link_up_in(cm_up), .line_rate_out(rate_c), .rx_enable_out(rx_c),
    .tx_enable_out(tx_c), .ver_out(ver_c), .ver_agreed_out(agr_c),
    .l1_ctrl_usable_out(use_c), .sup_expired_out(sup_c));
  lsn_equip_end #(.DWELL_CYC(DW_E), .EVAL_CYC(20), .SUP_CYC(5000)) lsn_equip_end_i (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .link(lsn_link_if_i), .start_in(start),
    .rate_mask_in(rmask), .ver_mask_in(vm_e), .hdlc_top_in(cmr), .eth_top_in(cmr),
    .hfn_sync_in(hfn_e), .cm_link_up_in(cm_up), .line_rate_out(rate_e), .rx_enable_out(rx_e),
    .tx_enable_out(tx_e), .ver_out(ver_e), .ver_agreed_out(agr_e),
    .l1_ctrl_usable_out(use_e), .sup_expired_out(sup_e));
  lsn_chk lsn_chk_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .link_clk(lsn_link_if_i.link_clk),
    .dl_tx_on(lsn_link_if_i.dl_tx_on), .dl_rate(lsn_link_if_i.dl_rate),
    .dl_ver(lsn_link_if_i.dl_ver), .ul_tx_on(lsn_link_if_i.ul_tx_on),
    .ul_rate(lsn_link_if_i.ul_rate));
  // 50 MHz clock
  always #10 clk_in = ~clk_in;
  // ==========================================================
  // Helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  // Wait on falling edges, where outputs are settled
  task automatic tick(input int k);
    repeat (k) @(negedge clk_in);
  endtask
  // Reset both ends, then start them
  task automatic go();
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    start <= 1'b0;
    hfn_c <= 1'b0;
    hfn_e <= 1'b0;
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1'b1;
    tick(2);
    check(rx_c, 1'b0);
    check(tx_c, 1'b0);
    check(tx_e, 1'b0);
    @(posedge clk_in);
    start <= 1'b1;
    tick(2);
  endtask
  task automatic finish_test();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (30000) @(posedge clk_in);
    bad_count++;
    finish_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    for (int r = 0; r < 3; r++) begin
      @(posedge clk_in);
      vm_c <= rows[r].vc;
      vm_e <= rows[r].ve;
      go();
      check(rate_c, 3'h3);
      check(tx_c, 1'b1);
      check(rx_e, 1'b1);
      check(tx_e, 1'b0);
      check(ver_c, 3'h3);
      // Downlink must be on before the far end can reach sync
      tick(8);
      @(posedge clk_in);
      hfn_c <= 1'b1;
      hfn_e <= 1'b1;
      tick(2);
      check(tx_e, 1'b1);
      check(use_c, 1'b0);
      n = 0;
      while (!(agr_c === 1'b1 && agr_e === 1'b1) && n < 3000) begin
        tick(1);
        n++;
      end
      check(ver_c, rows[r].v);
      check(ver_e, rows[r].v);
      check(agr_e, 1'b1);
      check(use_c, 1'b1);
      check(use_e, 1'b1);
    end
    // Lost sync leaves the agreed state
    @(posedge clk_in);
    hfn_c <= 1'b0;
    tick(3);
    check(agr_c, 1'b0);
    // Rate stepping without sync, then supervision expiry
    go();
    tick(DW_C - 5);
    check(rate_c, 3'h3);
    tick(10);
    check(rate_c, 3'h1);
    tick(DW_C);
    check(rate_c, 3'h3);
    tick(390);
    check(rate_e, 3'h3);
    tick(10);
    check(rate_e, 3'h1);
    n = 0;
    while (sup_c !== 1'b1 && n < 6000) begin
      tick(1);
      n++;
    end
    check(sup_c, 1'b1);
    check(sup_e, 1'b1);
    check(rate_c, 3'h3);
    tick(1);
    check(sup_c, 1'b0);
    check(sup_e, 1'b0);
    // Management link up stops supervision
    go();
    @(posedge clk_in);
    cm_up <= 1'b1;
    repeat (3) @(posedge clk_in);
    cm_up <= 1'b0;
    hits = 0;
    repeat (6000) begin
      tick(1);
      hits += (sup_c === 1'b1 || sup_e === 1'b1) ? 1 : 0;
    end
    check(8'(hits), 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire

// file: verif/lsn_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Checks on the link wires
module lsn_chk (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic link_clk,
  input wire logic dl_tx_on,
  input wire logic [lsn_pkg::RATE_W-1:0] dl_rate,
  input wire logic [lsn_pkg::VER_W-1:0] dl_ver,
  input wire logic ul_tx_on,
  input wire logic [lsn_pkg::RATE_W-1:0] ul_rate
);
  import lsn_pkg::*;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // ==========================================================
  // Link clock halves of four cycles
  sequence s_hi;
    link_clk [*4] ##1 !link_clk;
  endsequence
  sequence s_lo;
    !link_clk [*4] ##1 link_clk;
  endsequence
  property p_clk_hi;
    $rose(link_clk) |-> s_hi;
  endproperty
  a_clk_hi: assert property (p_clk_hi) else $error("link clock high half");
  property p_clk_lo;
    $fell(link_clk) |-> s_lo;
  endproperty
  a_clk_lo: assert property (p_clk_lo) else $error("link clock low half");
  // ==========================================================
  // Downlink words move only on a link clock fall
  property p_ver_edge;
    $changed(dl_ver) |-> $fell(link_clk) && dl_tx_on;
  endproperty
  a_ver_edge: assert property (p_ver_edge) else $error("version word off edge");
  property p_rate_edge;
    $changed(dl_rate) |-> $fell(link_clk);
  endproperty
  a_rate_edge: assert property (p_rate_edge) else $error("rate word off edge");
  property p_rate_on;
    $changed(dl_rate) |-> dl_tx_on;
  endproperty
  a_rate_on: assert property (p_rate_on) else $error("rate moved while idle");
  // Controller transmitter never drops outside reset
  property p_tx_hold;
    $past(dl_tx_on) |-> dl_tx_on;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("controller stopped");
  // Equipment sends only into an active downlink, at its rate
  property p_ul_off;
    !dl_tx_on |-> !ul_tx_on;
  endproperty
  a_ul_off: assert property (p_ul_off) else $error("uplink without downlink");
  property p_ul_start;
    $rose(ul_tx_on) |-> ul_rate == dl_rate;
  endproperty
  a_ul_start: assert property (p_ul_start) else $error("uplink rate differs");
endmodule
`default_nettype wire
